/* File: src/lssd_pkg.sv */
// shared constants and types of the sleep and decelerating-halt command decoder
`default_nettype none
package lssd_pkg;
    // ---------------------------------------------------------------
    // frame formats
    // ---------------------------------------------------------------
    localparam logic [5:0]  SLEEP_ID        = 6'h3C;
    localparam logic [7:0]  SLEEP_FIRST     = 8'h00;
    localparam logic [7:0]  SLEEP_FILL      = 8'hFF;
    localparam logic [3:0]  SLEEP_LEN       = 4'h8;
    localparam logic [3:0]  HALT_LEN        = 4'h2;
    localparam logic [6:0]  HALT_CMD        = 7'h0F;
    localparam int          MAX_BYTES       = 8;
    // ---------------------------------------------------------------
    // secure position
    // ---------------------------------------------------------------
    localparam logic [10:0] SECURE_POSITION_DISABLED = 11'h400;
    // ---------------------------------------------------------------
    // register map and fields
    // ---------------------------------------------------------------
    localparam logic [11:0] CTRL_OFF        = 12'h000;
    localparam logic [11:0] SECURE_POSITION_OFF      = 12'h004;
    localparam logic [11:0] TARGET_OFF      = 12'h008;
    localparam logic [11:0] STATUS_OFF      = 12'h00C;
    localparam int          CTRL_PERMIT_BIT = 0;
    localparam int          CTRL_NODE_LSB   = 8;
    localparam logic        PERMIT_RST      = 1'h0;
    localparam logic [6:0]  NODE_ADDR_RST   = 7'h00;
    localparam logic [10:0] SECURE_POSITION_RST      = 11'h400;
    localparam logic [15:0] TARGET_RST      = 16'h0000;
    // ---------------------------------------------------------------
    // control states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_HALTING = 3'b001,
        ST_SEEKING = 3'b010,
        ST_ASLEEP  = 3'b011,
        ST_STOPPED = 3'b100
    } lssd_state_t;
endpackage
`default_nettype wire

/* File: src/lssd_frame_decoder.sv */
// frame decoder: collects data bytes and recognises sleep and halt frames
`default_nettype none
module lssd_frame_decoder
(
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       frame_start_i,
    input  wire logic [5:0] frame_id_i,
    input  wire logic       byte_valid_i,
    input  wire logic [7:0] byte_i,
    input  wire logic       frame_end_i,
    output var  logic       sleep_req_o,
    output var  logic       halt_req_o,
    output var  logic       halt_group_o,
    output var  logic [6:0] halt_addr_o
);
    logic [7:0] data_r [lssd_pkg::MAX_BYTES];
    logic [3:0] count_r;
    logic [5:0] id_r;
    logic [lssd_pkg::MAX_BYTES-1:0] fill_ok;
    logic       sleep_hit;
    logic       halt_hit;

    // ---------------------------------------------------------------
    // byte capture
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            count_r <= 4'h0;
            id_r    <= 6'h00;
        end
        else if (frame_start_i)
        begin
            count_r <= 4'h0;
            id_r    <= frame_id_i;
        end
        else if (byte_valid_i && count_r != 4'hF)
        begin
            count_r <= count_r + 4'h1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < lssd_pkg::MAX_BYTES; g++)
        begin : g_byte
            always_ff @(posedge clk_i or posedge sys_rst_i)
            begin
                if (sys_rst_i)
                    data_r[g] <= 8'h00;
                else if (byte_valid_i && count_r == 4'(g))
                    data_r[g] <= byte_i;
            end
            if (g == 0)
            begin : g_first
                assign fill_ok[g] = (data_r[g] == lssd_pkg::SLEEP_FIRST);
            end
            else
            begin : g_rest
                assign fill_ok[g] = (data_r[g] == lssd_pkg::SLEEP_FILL);
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // classification at frame end
    // ---------------------------------------------------------------
    // sleep is a broadcast: every node accepts it
    assign sleep_hit = (id_r == lssd_pkg::SLEEP_ID) && (count_r == lssd_pkg::SLEEP_LEN)
                       && (&fill_ok);
    // the halt frame's identifier is dynamic, so only the frame length and the command byte decide
    assign halt_hit  = (count_r == lssd_pkg::HALT_LEN) && data_r[0][7]
                       && (data_r[0][6:0] == lssd_pkg::HALT_CMD);

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sleep_req_o  <= 1'b0;
            halt_req_o   <= 1'b0;
            halt_group_o <= 1'b0;
            halt_addr_o  <= 7'h00;
        end
        else
        begin
            sleep_req_o <= frame_end_i && sleep_hit;
            halt_req_o  <= frame_end_i && halt_hit;
            if (frame_end_i && halt_hit)
            begin
                halt_group_o <= data_r[1][7];
                halt_addr_o  <= data_r[1][6:0];
            end
        end
    end

    chk_sleep_frame_id: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        sleep_req_o |-> $past(id_r) == lssd_pkg::SLEEP_ID)
        else $error("sleep accepted with wrong identifier");
    chk_halt_cmd_byte: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        halt_req_o |-> $past(data_r[0]) == {1'b1, lssd_pkg::HALT_CMD})
        else $error("halt accepted with wrong command byte");
    chk_halt_any_id: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        frame_end_i && count_r == lssd_pkg::HALT_LEN && data_r[0] == {1'b1, lssd_pkg::HALT_CMD}
        |=> halt_req_o && halt_group_o == $past(data_r[1][7])
        && halt_addr_o == $past(data_r[1][6:0]))
        else $error("halt frame not recognised");
endmodule // lssd_frame_decoder
`default_nettype wire

/* File: src/lssd_top.sv */
// sleep and decelerating-halt command interpreter with apb register file
//
// The APB register port and the register addresses were left to the implementer.
`default_nettype none
module lssd_top
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output var  logic [31:0] prdata_o,
    output var  logic        pready_o,
    output var  logic        pslverr_o,
    input  wire logic        frame_start_i,
    input  wire logic [5:0]  frame_id_i,
    input  wire logic        byte_valid_i,
    input  wire logic [7:0]  byte_i,
    input  wire logic        frame_end_i,
    input  wire logic        motor_moving_i,
    input  wire logic [15:0] actual_position_i,
    input  wire logic        two_point_referencing_i,
    input  wire logic        thermal_shutdown_i,
    input  wire logic        third_undervoltage_level_i,
    output var  logic [15:0] target_position_o,
    output var  logic        decelerating_halt_o,
    output var  logic        sleep_o,
    output var  logic        stopped_o
);
    logic                  sleep_req;
    logic                  halt_req;
    logic                  halt_group;
    logic [6:0]            halt_addr;
    logic                  sleep_permit_r;
    logic [6:0]            node_addr_r;
    logic [10:0]           secure_position_r;
    logic                  thermal_q_r;
    logic                  uv3_q_r;
    logic                  sleep_pend_r;
    logic                  sleep_pend_nxt;
    lssd_pkg::lssd_state_t state_r;
    lssd_pkg::lssd_state_t state_nxt;
    logic                  addr_hit;
    logic                  auto_halt;
    logic                  halt_evt;
    logic                  secure_position_on;
    logic                  asleep_or_stop;
    logic                  apb_access;
    logic                  apb_wr;
    logic                  mapped;
    logic [31:0]           rdata_nxt;

    lssd_frame_decoder u_dec
    (
        .clk_i         (clk_i),
        .sys_rst_i     (sys_rst_i),
        .frame_start_i (frame_start_i),
        .frame_id_i    (frame_id_i),
        .byte_valid_i  (byte_valid_i),
        .byte_i        (byte_i),
        .frame_end_i   (frame_end_i),
        .sleep_req_o   (sleep_req),
        .halt_req_o    (halt_req),
        .halt_group_o  (halt_group),
        .halt_addr_o   (halt_addr)
    );

    // ---------------------------------------------------------------
    // apb slave: one wait state, writes commit on the pready edge
    // ---------------------------------------------------------------
    assign apb_access = psel_i && penable_i && !pready_o;
    assign apb_wr     = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
    assign mapped     = (paddr_i == lssd_pkg::CTRL_OFF) || (paddr_i == lssd_pkg::SECURE_POSITION_OFF)
                        || (paddr_i == lssd_pkg::TARGET_OFF) || (paddr_i == lssd_pkg::STATUS_OFF);

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        case (paddr_i)
            lssd_pkg::CTRL_OFF:
            begin
                rdata_nxt[lssd_pkg::CTRL_PERMIT_BIT] = sleep_permit_r;
                rdata_nxt[lssd_pkg::CTRL_NODE_LSB +: 7] = node_addr_r;
            end
            lssd_pkg::SECURE_POSITION_OFF: rdata_nxt[10:0] = secure_position_r;
            lssd_pkg::TARGET_OFF: rdata_nxt[15:0] = target_position_o;
            lssd_pkg::STATUS_OFF:
                rdata_nxt = {actual_position_i, 8'h00, motor_moving_i, stopped_o, sleep_o,
                             decelerating_halt_o, sleep_pend_r, state_r};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end
        else
        begin
            pready_o  <= apb_access;
            pslverr_o <= apb_access && !mapped;
            if (apb_access)
                prdata_o <= pwrite_i ? 32'h0000_0000 : rdata_nxt;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sleep_permit_r    <= lssd_pkg::PERMIT_RST;
            node_addr_r       <= lssd_pkg::NODE_ADDR_RST;
            secure_position_r <= lssd_pkg::SECURE_POSITION_RST;
        end
        else if (apb_wr && paddr_i == lssd_pkg::CTRL_OFF)
        begin
            sleep_permit_r <= pwdata_i[lssd_pkg::CTRL_PERMIT_BIT];
            node_addr_r    <= pwdata_i[lssd_pkg::CTRL_NODE_LSB +: 7];
        end
        else if (apb_wr && paddr_i == lssd_pkg::SECURE_POSITION_OFF)
        begin
            secure_position_r <= pwdata_i[10:0];
        end
    end

    // ---------------------------------------------------------------
    // halt triggers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            thermal_q_r <= 1'b0;
            uv3_q_r     <= 1'b0;
        end
        else
        begin
            thermal_q_r <= thermal_shutdown_i;
            uv3_q_r     <= third_undervoltage_level_i;
        end
    end

    // a fault that stays asserted fires once, on its rising edge
    assign addr_hit  = !halt_group || (halt_addr == node_addr_r);
    assign auto_halt = (thermal_shutdown_i && !thermal_q_r)
                       || (third_undervoltage_level_i && !uv3_q_r);
    assign halt_evt  = ((halt_req && addr_hit) || auto_halt) && !two_point_referencing_i;
    assign secure_position_on = (secure_position_r != lssd_pkg::SECURE_POSITION_DISABLED);

    // ---------------------------------------------------------------
    // control state machine
    // ---------------------------------------------------------------
    always_comb
    begin
        state_nxt      = state_r;
        sleep_pend_nxt = sleep_pend_r;
        case (state_r)
            lssd_pkg::ST_IDLE:
            begin
                if (sleep_req && motor_moving_i && secure_position_on)
                begin
                    state_nxt      = lssd_pkg::ST_SEEKING;
                    sleep_pend_nxt = 1'b1;
                end
                else if (sleep_req && motor_moving_i)
                begin
                    state_nxt      = lssd_pkg::ST_HALTING;
                    sleep_pend_nxt = 1'b1;
                end
                else if (sleep_req)
                    state_nxt = sleep_permit_r ? lssd_pkg::ST_ASLEEP : lssd_pkg::ST_STOPPED;
                else if (halt_evt && motor_moving_i)
                    state_nxt = lssd_pkg::ST_HALTING;
            end
            lssd_pkg::ST_HALTING:
            begin
                if (sleep_req)
                    sleep_pend_nxt = 1'b1;
                if (!motor_moving_i && (sleep_pend_r || sleep_req))
                begin
                    state_nxt = sleep_permit_r ? lssd_pkg::ST_ASLEEP : lssd_pkg::ST_STOPPED;
                end
                else if (!motor_moving_i)
                    state_nxt = lssd_pkg::ST_IDLE;
            end
            lssd_pkg::ST_SEEKING:
            begin
                if (halt_evt && motor_moving_i)
                    state_nxt = lssd_pkg::ST_HALTING;
                else if (!motor_moving_i)
                    state_nxt = sleep_permit_r ? lssd_pkg::ST_ASLEEP : lssd_pkg::ST_STOPPED;
            end
            lssd_pkg::ST_ASLEEP, lssd_pkg::ST_STOPPED:
            begin
                sleep_pend_nxt = 1'b0;
                // a fresh set point from software resumes normal operation
                if (apb_wr && paddr_i == lssd_pkg::TARGET_OFF)
                    state_nxt = lssd_pkg::ST_IDLE;
            end
            default:
            begin
                state_nxt      = lssd_pkg::ST_IDLE;
                sleep_pend_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_r             <= lssd_pkg::ST_IDLE;
            sleep_pend_r        <= 1'b0;
            decelerating_halt_o <= 1'b0;
            sleep_o             <= 1'b0;
            stopped_o           <= 1'b0;
        end
        else
        begin
            state_r             <= state_nxt;
            sleep_pend_r        <= sleep_pend_nxt;
            decelerating_halt_o <= (state_nxt == lssd_pkg::ST_HALTING);
            sleep_o             <= (state_nxt == lssd_pkg::ST_ASLEEP);
            stopped_o           <= (state_nxt == lssd_pkg::ST_STOPPED);
        end
    end

    // ---------------------------------------------------------------
    // target position
    // ---------------------------------------------------------------
    // software write wins over a same-cycle hardware load
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            target_position_o <= lssd_pkg::TARGET_RST;
        else if (apb_wr && paddr_i == lssd_pkg::TARGET_OFF)
            target_position_o <= pwdata_i[15:0];
        else if (state_r == lssd_pkg::ST_IDLE && state_nxt == lssd_pkg::ST_SEEKING)
            target_position_o <= {{5{secure_position_r[10]}}, secure_position_r};
        else if (state_r == lssd_pkg::ST_HALTING && !motor_moving_i)
            target_position_o <= actual_position_i;
    end

    assign asleep_or_stop = sleep_o || stopped_o;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_sleep_needs_permit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(sleep_o) |-> $past(sleep_permit_r) && !stopped_o)
        else $error("asleep without sleep permit");
    chk_secure_position_load: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_r == lssd_pkg::ST_IDLE && sleep_req && motor_moving_i && secure_position_on
        && !apb_wr |=> target_position_o == {{5{$past(secure_position_r[10])}},
        $past(secure_position_r)})
        else $error("secure position not loaded on sleep");
    chk_secure_position_off_halt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_r == lssd_pkg::ST_IDLE && sleep_req && motor_moving_i && !secure_position_on
        |=> decelerating_halt_o && sleep_pend_r)
        else $error("disabled secure position did not halt");
    chk_halt_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        decelerating_halt_o && motor_moving_i && state_r == lssd_pkg::ST_HALTING
        |=> decelerating_halt_o)
        else $error("halt released while still moving");
    chk_stop_copies_pos: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_r == lssd_pkg::ST_HALTING && !motor_moving_i && !apb_wr
        |=> target_position_o == $past(actual_position_i) && !decelerating_halt_o)
        else $error("stop position not held");
    chk_ref_ignores_halt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_r == lssd_pkg::ST_IDLE && two_point_referencing_i && !sleep_req
        |=> !decelerating_halt_o)
        else $error("halt taken during referencing");
    chk_thermal_halt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_r == lssd_pkg::ST_IDLE && $rose(thermal_shutdown_i) && motor_moving_i
        && !two_point_referencing_i && !sleep_req |=> decelerating_halt_o)
        else $error("thermal shutdown did not halt");
    chk_uv3_halt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_r == lssd_pkg::ST_IDLE && $rose(third_undervoltage_level_i) && motor_moving_i
        && !two_point_referencing_i && !sleep_req |=> decelerating_halt_o)
        else $error("undervoltage did not halt");
    chk_broadcast_halt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_r == lssd_pkg::ST_IDLE && halt_req && !halt_group && motor_moving_i
        && !two_point_referencing_i && !sleep_req |=> decelerating_halt_o)
        else $error("broadcast halt ignored");
    chk_addr_filter: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_r == lssd_pkg::ST_IDLE && halt_req && halt_group && halt_addr != node_addr_r
        && !auto_halt && !sleep_req |=> !decelerating_halt_o)
        else $error("halt taken for another node");

    cov_halt_stop: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        decelerating_halt_o ##1 !decelerating_halt_o && !asleep_or_stop);
    cov_seek_sleep: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        state_r == lssd_pkg::ST_SEEKING ##[1:20] sleep_o);
    cov_stopped: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(stopped_o));
endmodule // lssd_top
`default_nettype wire

/* File: tb/lssd_lin_master.sv */
// bus master model: serialises one frame per send request
`default_nettype none
module lssd_lin_master
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        send_i,
    input  wire logic [5:0]  id_i,
    input  wire logic [3:0]  len_i,
    input  wire logic [63:0] data_i,
    output var  logic        frame_start_o,
    output var  logic [5:0]  frame_id_o,
    output var  logic        byte_valid_o,
    output var  logic [7:0]  byte_o,
    output var  logic        frame_end_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        busy_r;
    logic [3:0]  cnt_r;
    logic [63:0] sh_r;
    // data byte 1 goes first; the idle byte lane toggles so stale data never looks valid
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            {frame_start_o, byte_valid_o, frame_end_o, busy_r} <= 4'h0;
            {frame_id_o, byte_o, cnt_r, sh_r} <= '0;
        end
        else
        begin
            frame_start_o <= send_i;
            byte_valid_o  <= 1'b0;
            frame_end_o   <= 1'b0;
            byte_o        <= ~byte_o;
            if (send_i)
            begin
                frame_id_o <= id_i;
                sh_r       <= data_i;
                cnt_r      <= len_i;
                busy_r     <= 1'b1;
            end
            else if (busy_r && cnt_r != 4'h0)
            begin
                byte_valid_o <= 1'b1;
                byte_o       <= sh_r[63:56];
                sh_r         <= sh_r << 8;
                cnt_r        <= cnt_r - 4'h1;
            end
            else if (busy_r)
            begin
                frame_end_o <= 1'b1;
                busy_r      <= 1'b0;
            end
        end
    end
endmodule // lssd_lin_master
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench of the sleep and halt command interpreter
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst = 1, psel = 0, pen = 0, pwr = 0, send = 0;
    logic mov = 0, rf = 0, th = 0, uv = 0, fs, bv, fe, rdy, err, hlt, slp, stp, e;
    logic [11:0] pa = '0;
    logic [31:0] pwd = '0, prd, r, seed = 32'h5087980D;
    logic [5:0]  sid = '0, fid;
    logic [3:0]  sln = '0;
    logic [63:0] sd = '0;
    logic [15:0] act = '0, tgt, et;
    logic [7:0]  fb;
    logic [6:0]  nd;
    int miscompares = 0, checks_done = 0;
    always #4 clk_i = ~clk_i;
    lssd_lin_master mst (.clk_i(clk_i), .sys_rst_i(rst), .send_i(send), .id_i(sid),
        .len_i(sln), .data_i(sd), .frame_start_o(fs), .frame_id_o(fid),
        .byte_valid_o(bv), .byte_o(fb), .frame_end_o(fe));
    lssd_top uut (.clk_i(clk_i), .sys_rst_i(rst), .paddr_i(pa), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
        .pslverr_o(err), .frame_start_i(fs), .frame_id_i(fid), .byte_valid_i(bv),
        .byte_i(fb), .frame_end_i(fe), .motor_moving_i(mov), .actual_position_i(act),
        .two_point_referencing_i(rf), .thermal_shutdown_i(th),
        .third_undervoltage_level_i(uv), .target_position_o(tgt),
        .decelerating_halt_o(hlt), .sleep_o(slp), .stopped_o(stp));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [63:0] hfr(input logic g, input logic [6:0] a);
        return {1'b1, lssd_pkg::HALT_CMD, g, a, 48'h0};
    endfunction
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until pready is sampled high, then released after that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge clk_i);
            if (rdy === 1'b1) break;
        end
        if (i == 16) begin miscompares++; summarize(); end
        r = prd; e = err; psel <= 1'b0; pen <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, '0);
        chk(r, x);
        chk(e, xe);
    endtask
    // frame visible on the outputs two cycles after its end pulse
    task automatic fr(input logic [5:0] id, input logic [3:0] n, input logic [63:0] d);
        send <= 1'b1; sid <= id; sln <= n; sd <= d;
        @(posedge clk_i);
        send <= 1'b0;
        repeat (n + 6) @(posedge clk_i);
    endtask
    task automatic stop_motor;
        mov <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst <= 1'b0;
        @(posedge clk_i);
        rd(lssd_pkg::CTRL_OFF, 32'h0, 1'b0);
        rd(lssd_pkg::SECURE_POSITION_OFF, 32'h400, 1'b0);
        rd(lssd_pkg::TARGET_OFF, 32'h0, 1'b0);
        rd(12'h010, 32'h0, 1'b1);
        $display("test registers done");
        seed = lfsr(seed); nd = seed[6:0]; et = '0;
        apb(1'b1, lssd_pkg::CTRL_OFF, {17'h0, nd, 8'h01});
        for (int k = 0; k < 6; k++)
        begin
            seed = lfsr(seed); act <= seed[15:0]; mov <= 1'b1; rf <= (k == 3);
            th <= (k == 4); uv <= (k == 5);
            if (k < 4) fr(seed[21:16], 4'h2, hfr(k[0], (k == 1) ? ~nd : nd));
            else repeat (4) @(posedge clk_i);
            chk(hlt, k != 1 && k != 3);
            if (k != 1 && k != 3) et = act;
            {rf, th, uv} <= 3'b000;
            stop_motor();
            chk(tgt, et);
            chk(hlt, 1'b0);
        end
        $display("test halt done");
        apb(1'b1, lssd_pkg::SECURE_POSITION_OFF, 32'h7F0);
        mov <= 1'b1;
        fr(lssd_pkg::SLEEP_ID, 4'h8, 64'h00FFFFFFFFFFFFFF);
        chk(tgt, 32'hFFF0);
        chk(slp, 1'b0);
        stop_motor();
        chk(slp, 1'b1);
        rd(lssd_pkg::STATUS_OFF, {act, 16'h0023}, 1'b0);
        seed = lfsr(seed);
        apb(1'b1, lssd_pkg::TARGET_OFF, {16'h0, seed[15:0]});
        chk(slp, 1'b0);
        chk(tgt, seed[15:0]);
        apb(1'b1, lssd_pkg::SECURE_POSITION_OFF, 32'h400);
        apb(1'b1, lssd_pkg::CTRL_OFF, {17'h0, nd, 8'h00});
        mov <= 1'b1;
        fr(lssd_pkg::SLEEP_ID, 4'h8, 64'h00FFFFFFFFFFFFFF);
        chk(hlt, 1'b1);
        stop_motor();
        chk(stp, 1'b1);
        chk(slp, 1'b0);
        chk(tgt, act);
        apb(1'b1, lssd_pkg::TARGET_OFF, 32'h0);
        // near misses of the sleep frame must leave the node idle
        fr(lssd_pkg::SLEEP_ID, 4'h8, 64'h00FFFFFFFFFFFF7F);
        fr(6'h3D, 4'h8, 64'h00FFFFFFFFFFFFFF);
        chk({slp, stp}, 2'b00);
        $display("test sleep done");
        summarize();
    end
endmodule // tb
`default_nettype wire
